/* File: core/reload_timer_fine.sv */
// Operation
// - Count clock is peripheral clock over two to the 4-bit code; code F reserved.
// - Eight-bit reload value, read and write, zero after reset, reloads counter.
// - Live eight-bit count is read-only and reads FF after reset.
// - Four-bit fine setting: delays inserted per sixteen underflows; zero inserts none.
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module reload_timer_fine (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [timer_fine_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Timer event
	output logic underflow_out
);
	import timer_fine_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [3:0] clock_div_code_q;
	logic [7:0] reload_value_field_q;
	logic [7:0] count_value_field_q;
	logic [3:0] fine_insert_count_q;
	logic one_shot_select_q;
	logic run_control_q;
	logic delay_q;
	logic [3:0] uf_index_q;
	logic count_tick;

	// ----------------------------------------
	// Count clock
	// ----------------------------------------
	count_prescaler count_prescaler_i (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.code_in(clock_div_code_q),
		.tick_out(count_tick)
	);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic setup_phase;
	logic access_wr;
	logic hit_clk;
	logic hit_reload;
	logic hit_count;
	logic hit_control;
	logic hit_any;
	logic wr_lo;
	logic wr_hi;
	logic wr_clk;
	logic wr_reload;
	logic wr_control_lo;
	logic wr_control_hi;
	logic counter_reset_strobe;

	// Writes land only on the completing access edge
	assign setup_phase = psel_in && !penable_in;
	assign access_wr = psel_in && penable_in && pwrite_in && pready_out;
	assign hit_clk = (paddr_in == ADDR_CLK_SEL);
	assign hit_reload = (paddr_in == ADDR_RELOAD);
	assign hit_count = (paddr_in == ADDR_COUNT);
	assign hit_control = (paddr_in == ADDR_CONTROL);
	assign hit_any = hit_clk || hit_reload || hit_count || hit_control;
	assign wr_lo = access_wr && pstrb_in[0];
	assign wr_hi = access_wr && pstrb_in[1];
	assign wr_clk = wr_lo && hit_clk;
	assign wr_reload = wr_lo && hit_reload;
	assign wr_control_lo = wr_lo && hit_control;
	assign wr_control_hi = wr_hi && hit_control;
	// Count register has no write path, so writes to it just complete
	// Writing zero to the reset bit does nothing
	assign counter_reset_strobe = wr_control_lo && pwdata_in[RESET_BIT];

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [15:0] rd_clk;
	logic [15:0] rd_reload;
	logic [15:0] rd_count;
	logic [15:0] rd_control;
	logic [15:0] rd_word;

	// Reserved bits and the write-only reset bit read as zero
	assign rd_clk = {12'h000, clock_div_code_q};
	assign rd_reload = {8'h00, reload_value_field_q};
	assign rd_count = {8'h00, count_value_field_q};
	assign rd_control = {4'h0, fine_insert_count_q, 3'h0, one_shot_select_q, 3'h0,
		run_control_q};
	assign rd_word = hit_clk ? rd_clk :
		hit_reload ? rd_reload :
		hit_count ? rd_count :
		hit_control ? rd_control : 16'h0000;

	// Answer registered in setup so every access has no wait state
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end else begin
			pready_out <= setup_phase;
			pslverr_out <= setup_phase && !hit_any;
			prdata_out <= (setup_phase && !pwrite_in) ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Settings take effect on the next count clock
	// A new divide code lands mid-period, so the first period after it may be short
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clock_div_code_q <= DIV_RESET;
			reload_value_field_q <= RELOAD_RESET;
			fine_insert_count_q <= FINE_RESET;
			one_shot_select_q <= ONE_SHOT_RESET;
		end else begin
			if (wr_clk)
				clock_div_code_q <= pwdata_in[DIV_LSB +: 4];
			if (wr_reload)
				reload_value_field_q <= pwdata_in[7:0];
			if (wr_control_hi)
				fine_insert_count_q <= pwdata_in[FINE_LSB +: 4];
			if (wr_control_lo)
				one_shot_select_q <= pwdata_in[ONE_SHOT_BIT];
		end
	end

	// ----------------------------------------
	// Down counter with fine delay insertion
	// ----------------------------------------
	logic step;
	logic at_zero;
	logic insert_now;
	logic reload_now;

	// An underflow index below the fine setting gets one extra count clock
	assign step = run_control_q && count_tick;
	assign at_zero = (count_value_field_q == 8'h00);
	assign insert_now = (uf_index_q < fine_insert_count_q) && !delay_q;
	assign reload_now = step && at_zero && !insert_now;

	// Reset strobe outranks counting in the same cycle
	// so the count always equals the reload value on the edge after a strobe
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_value_field_q <= COUNT_RESET;
			delay_q <= 1'b0;
			uf_index_q <= 4'h0;
		end else if (counter_reset_strobe) begin
			count_value_field_q <= reload_value_field_q;
			delay_q <= 1'b0;
			uf_index_q <= 4'h0;
		end else if (step && !at_zero) begin
			count_value_field_q <= count_value_field_q - 8'h01;
		end else if (step && insert_now) begin
			delay_q <= 1'b1;
		end else if (reload_now) begin
			count_value_field_q <= reload_value_field_q;
			delay_q <= 1'b0;
			uf_index_q <= uf_index_q + 4'h1;
		end
	end

	// Run bit; a software write beats a one-shot stop in the same cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			run_control_q <= RUN_RESET;
		end else if (wr_control_lo) begin
			run_control_q <= pwdata_in[RUN_BIT];
		end else if (reload_now && one_shot_select_q) begin
			run_control_q <= 1'b0;
		end
	end

	// Underflow pulse for neighbouring logic
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			underflow_out <= 1'b0;
		else
			underflow_out <= reload_now && !counter_reset_strobe;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	bus_ready_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		setup_phase |=> pready_out)
		else $error("no ready in access phase");

	reload_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		wr_reload |=> reload_value_field_q == $past(pwdata_in[7:0]))
		else $error("reload value not written");

	count_stop_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(!run_control_q && !counter_reset_strobe) |=> $stable(count_value_field_q))
		else $error("count moved while stopped");

	count_step_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(step && !at_zero && !counter_reset_strobe)
		|=> count_value_field_q == $past(count_value_field_q) - 8'h01)
		else $error("count did not step down");

	fine_delay_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(step && at_zero && insert_now && !counter_reset_strobe)
		|=> (count_value_field_q == 8'h00) && delay_q && !underflow_out)
		else $error("fine delay not inserted");

	fine_none_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(fine_insert_count_q == 4'h0 && step && at_zero && !counter_reset_strobe)
		|=> underflow_out)
		else $error("delay inserted with fine off");

	one_shot_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(reload_now && one_shot_select_q && !wr_control_lo) |=> !run_control_q ##1 !underflow_out)
		else $error("one-shot kept running");

	reset_strobe_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		counter_reset_strobe |=> count_value_field_q == $past(reload_value_field_q) && !delay_q)
		else $error("reset strobe did not reload");

	// ----------------------------------------
	// Bus answer checks
	// ----------------------------------------
	// Ready stands only in the access cycle that follows a setup
	bus_idle_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!setup_phase |=> !pready_out)
		else $error("ready outside access phase");

	// Unmapped addresses answer with an error, mapped ones never do
	bus_error_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		setup_phase |=> pslverr_out == !$past(hit_any))
		else $error("error flag does not match decode");

	// Zero outside a read so a stale word never leaks onto the bus
	read_idle_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!(setup_phase && !pwrite_in) |=> prdata_out == 32'h0000_0000)
		else $error("read data outside read access");

	read_count_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(setup_phase && !pwrite_in && hit_count)
		|=> prdata_out == {24'h00_0000, $past(count_value_field_q)})
		else $error("count read wrong");

	// ----------------------------------------
	// Register write checks
	// ----------------------------------------
	div_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		wr_clk |=> clock_div_code_q == $past(pwdata_in[3:0]))
		else $error("divide code not written");

	// Settings hold between writes; the counter relies on them staying put
	div_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!wr_clk |=> $stable(clock_div_code_q))
		else $error("divide code changed without write");

	reload_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!wr_reload |=> $stable(reload_value_field_q))
		else $error("reload value changed without write");

	fine_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		wr_control_hi |=> fine_insert_count_q == $past(pwdata_in[11:8]))
		else $error("fine setting not written");

	run_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		wr_control_lo |=> run_control_q == $past(pwdata_in[0]))
		else $error("run bit not written");

	// Only software or a one-shot underflow may move the run bit
	run_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(!wr_control_lo && !(reload_now && one_shot_select_q)) |=> $stable(run_control_q))
		else $error("run bit moved on its own");

	// ----------------------------------------
	// Reload checks
	// ----------------------------------------
	// A reload brings back the stored value and clears any pending delay
	reload_count_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(reload_now && !counter_reset_strobe)
		|=> (count_value_field_q == $past(reload_value_field_q)) && !delay_q && underflow_out)
		else $error("reload did not restore count");

	// The index wraps after sixteen underflows so the pattern repeats
	fine_index_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(reload_now && !counter_reset_strobe)
		|=> uf_index_q == $past(uf_index_q) + 4'h1)
		else $error("underflow index did not advance");

	// A served delay lets the next count clock reload at once
	fine_served_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(step && at_zero && delay_q && !counter_reset_strobe) |=> underflow_out)
		else $error("delay held too long");
endmodule
`default_nettype wire

/* File: core/timer_fine_pkg.sv */
package timer_fine_pkg;
	// ----------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_CLK_SEL = 16'h4200;
	localparam logic [15:0] IDX_RELOAD = 16'h4202;
	localparam logic [15:0] IDX_COUNT = 16'h4204;
	localparam logic [15:0] IDX_CONTROL = 16'h4206;
	localparam logic [ADDR_W-1:0] ADDR_CLK_SEL = {IDX_CLK_SEL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_RELOAD = {IDX_RELOAD, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DIV_LSB = 0;
	localparam int RUN_BIT = 0;
	localparam int RESET_BIT = 1;
	localparam int ONE_SHOT_BIT = 4;
	localparam int FINE_LSB = 8;

	// ----------------------------------------
	// Reset values and special codes
	// ----------------------------------------
	localparam logic [3:0] DIV_RESET = 4'h0;
	localparam logic [3:0] DIV_RESERVED = 4'hF;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'hFF;
	localparam logic [3:0] FINE_RESET = 4'h0;
	localparam logic ONE_SHOT_RESET = 1'b0;
	localparam logic RUN_RESET = 1'b0;
endpackage

/* File: core/count_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
module count_prescaler (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Division select
	input wire logic [3:0] code_in,
	// One-cycle count clock enable
	output logic tick_out
);
	import timer_fine_pkg::*;

	logic [13:0] div_cnt_q;
	logic [14:0] one_hot;
	logic [13:0] mask;
	logic tick_d;

	// Tick when the low code bits of the free counter are all ones
	assign one_hot = 15'h0001 << code_in;
	assign mask = 14'(one_hot - 15'h0001);
	assign tick_d = (code_in != DIV_RESERVED) && ((div_cnt_q & mask) == mask);

	// Free-running divider; never reset by software so phase is shared
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_cnt_q <= 14'h0000;
			tick_out <= 1'b0;
		end else begin
			div_cnt_q <= div_cnt_q + 14'h0001;
			tick_out <= tick_d;
		end
	end

	div_full_rate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(code_in == 4'h0) |=> tick_out)
		else $error("divide by one gives no tick");
	div_reserved_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(code_in == 4'hF) |=> !tick_out)
		else $error("reserved divide code ticks");
endmodule
`default_nettype wire

/* File: verification/tb_reload_timer_fine.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_reload_timer_fine;
	import timer_fine_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk_in, arst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, underflow_out;
	logic [ADDR_W-1:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic [3:0] pstrb_in;
	logic er;
	int err_count, comparisons, n, sum;
	reload_timer_fine reload_timer_fine_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .underflow_out(underflow_out));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Compare and count; one line per mismatch
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// APB transfer; waits on pready, never assumes wait states
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d,
		input logic [3:0] s);
		int k;
		k = 0;
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= {16'h0000, d};
		pstrb_in <= s;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
			k++;
		end while (pready_out !== 1'b1 && k < 20);
		if (k >= 20) chk("pready", 32'h1, 32'h0);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		// One idle edge so a following call never reassigns psel in this step
		@(posedge clk_in);
	endtask
	task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
		apb(1'b0, a, 16'h0000, 4'h0);
		chk(nm, e, rd);
	endtask
	// Edges up to the next underflow pulse, bounded
	task automatic wait_uf(output int c);
		c = 0;
		do begin
			@(posedge clk_in);
			c++;
		end while (underflow_out !== 1'b1 && c < 2000);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rchk("clk_sel", ADDR_CLK_SEL, 32'h0);
		chk("err", 32'h0, {31'h0, er});
		rchk("reload", ADDR_RELOAD, 32'h0);
		rchk("count", ADDR_COUNT, 32'hFF);
		rchk("control", ADDR_CONTROL, 32'h0);
		rchk("unmapped", ADDR_CONTROL + 18'h4, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		$display("test reset done");
	endtask
	task automatic t_regs;
		apb(1'b1, ADDR_RELOAD, 16'hFFA5, 4'hF);
		rchk("reload", ADDR_RELOAD, 32'hA5);
		apb(1'b1, ADDR_RELOAD, 16'h0055, 4'h2); // Low byte strobe off: kept
		rchk("reload strb", ADDR_RELOAD, 32'hA5);
		apb(1'b1, ADDR_COUNT, 16'h0012, 4'hF);
		rchk("count ro", ADDR_COUNT, 32'hFF);
		apb(1'b1, ADDR_CLK_SEL, 16'hFFFE, 4'hF);
		rchk("clk_sel", ADDR_CLK_SEL, 32'hE);
		$display("test registers done");
	endtask
	// Period is (reload+1) count clocks of 2^code cycles; first pulse has free prescaler phase
	task automatic t_div;
		apb(1'b1, ADDR_RELOAD, 16'h0003, 4'hF);
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ADDR_CLK_SEL, 16'(c), 4'hF);
			apb(1'b1, ADDR_CONTROL, 16'h0003, 4'hF);
			wait_uf(n);
			wait_uf(n);
			chk("period", 32'(4 << c), 32'(n));
			apb(1'b1, ADDR_CONTROL, 16'h0000, 4'hF);
		end
		apb(1'b1, ADDR_CLK_SEL, {12'h000, DIV_RESERVED}, 4'hF);
		apb(1'b1, ADDR_CONTROL, 16'h0003, 4'hF);
		repeat (50) @(posedge clk_in);
		rchk("frozen count", ADDR_COUNT, 32'h3);
		apb(1'b1, ADDR_CONTROL, 16'h0000, 4'hF);
		$display("test divider done");
	endtask
	// Sixteen underflows span sixteen periods plus one count clock per insertion
	task automatic t_fine;
		apb(1'b1, ADDR_CLK_SEL, 16'h0000, 4'hF);
		apb(1'b1, ADDR_CONTROL, 16'h0203, 4'hF);
		rchk("control", ADDR_CONTROL, 32'h0201);
		wait_uf(n);
		sum = 0;
		for (int i = 0; i < 16; i++) begin
			wait_uf(n);
			sum += n;
		end
		chk("fine span", 32'd66, 32'(sum));
		apb(1'b1, ADDR_CONTROL, 16'h0000, 4'hF);
		$display("test fine done");
	endtask
	task automatic t_oneshot;
		apb(1'b1, ADDR_RELOAD, 16'h0002, 4'hF);
		apb(1'b1, ADDR_CONTROL, 16'h0013, 4'hF);
		wait_uf(n);
		wait_uf(n);
		chk("one shot stop", 32'd2000, 32'(n));
		rchk("count held", ADDR_COUNT, 32'h2);
		apb(1'b1, ADDR_RELOAD, 16'h0007, 4'hF);
		apb(1'b1, ADDR_CONTROL, 16'h0010, 4'hF);
		rchk("strobe zero", ADDR_COUNT, 32'h2);
		apb(1'b1, ADDR_CONTROL, 16'h0002, 4'hF);
		rchk("strobe one", ADDR_COUNT, 32'h7);
		rchk("control wo", ADDR_CONTROL, 32'h0);
		$display("test one shot done");
	endtask
	// ----------------------------------------
	// Run control and verdict
	// ----------------------------------------
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// Whole run is a few thousand cycles; this is far past it
	initial begin
		#400000;
		err_count++;
		end_sim;
	end
	initial begin
		err_count = 0;
		comparisons = 0;
		arst_n_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = '0;
		pwdata_in = '0;
		pstrb_in = 4'h0;
		repeat (10) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(posedge clk_in);
		t_reset;
		t_regs;
		t_div;
		t_fine;
		t_oneshot;
		end_sim;
	end
endmodule
`default_nettype wire
